/* File: dv/testbench.sv */
// Purpose: self-checking bench for the ULPI pin mode block
// Assumes: link clock 30 ns, system clock 4 ns, dir delay shortened to 4
// Notes:   link model drives STP and free data pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import upm_pkg::*;
    logic sys_clk, rst_n, ulpiClk, extRstN, pll, stpOff, perRole, lsReq, inSusp, stpLvl;
    upm_mode_e modeSel;
    logic [7:0] linkDrive, linkOe, dataIn, dataOut, dataOe, dataPd;
    logic stpIn, dirOut, dirOe, dirPu, nxtOut, nxtOe, nxtPd, stpPu, clkIn, clkPd, padRst;
    logic txEn, txDat, txSe0, uTxd, cdrIn, lsOk;
    logic clkEn, lsDp, lsDm, diffC, intL, sDo, sDoe, sSo, sSoe, uRx, dirL, nxtL;
    logic [7:0] lnkOut;
    logic [2:0] modeAct;
    int failures = 0;
    int tests_run = 0;
    // ****************************************
    // clocks and instances
    // ****************************************
    initial
    begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        ulpiClk = 0;
        #7.3;
        forever #15 ulpiClk = ~ulpiClk;
    end
    upm_pin_mode #(.DIR_DELAY_CYC(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .ulpiClk(ulpiClk),
        .externalResetN(extRstN), .pllLocked(pll), .modeSel(modeSel), .stpPullOffInSuspend(stpOff),
        .peripheralRole(perRole), .lowSpeedReq(lsReq), .lineStateDp(lsDp), .lineStateDm(lsDm),
        .diffCompOut(diffC), .intLevel(intL), .serDatOut(sDo), .serDatOe(sDoe), .serSe0Out(sSo),
        .serSe0Oe(sSoe), .uartRxd(uRx), .dirLevel(dirL), .nxtLevel(nxtL), .linkDataOut(lnkOut),
        .dataIn(dataIn), .stpIn(stpIn), .dataOut(dataOut), .dataOe(dataOe), .dataPullDown(dataPd),
        .dirOut(dirOut), .dirOe(dirOe), .dirPullUp(dirPu), .nxtOut(nxtOut), .nxtOe(nxtOe),
        .nxtPullDown(nxtPd), .stpPullUp(stpPu), .clkPinIsInput(clkIn), .clkPinPullDown(clkPd),
        .padResetInternal(padRst), .txEnable(txEn), .txData(txDat), .txSe0(txSe0), .uartTxd(uTxd),
        .cdrIn(cdrIn), .lowSpeedAllowed(lsOk), .modeActive(modeAct));
    upm_link_model LINK (.ulpiClk(ulpiClk), .inSuspend(inSusp), .stpLevel(stpLvl), .linkDrive(linkDrive),
        .linkOe(linkOe), .dataOut(dataOut), .dataOe(dataOe), .dataPullDown(dataPd), .dataIn(dataIn),
        .stpIn(stpIn));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge ulpiClk);
        @(posedge sys_clk);
        #1;
    endtask
    task automatic setm(input upm_mode_e m);
        modeSel = m;
        go(12);
        chk("ctl", {5'h00, 2'b11, ~(m == UPM_MODE_SUSPEND && stpOff)}, {5'h00, dirOe, nxtOe, stpPu});
        chk("mode", {5'h00, m}, {5'h00, modeAct});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_powerup;
        chk("rst", 8'h1F, {dirOe, nxtOe, dirPu, stpPu, nxtPd, clkPd, padRst});
        chk("rstOe", 8'h00, dataOe);
        chk("rstPd", 8'hFF, dataPd);
        extRstN = 1;
        go(4);
        chk("off", 8'h1B, {dirOut, dirOe, nxtOut, nxtOe, clkIn});
        chk("offD", 8'hFF, {dataOe[7:1], ~dataOut[0]} & {7'h7F, ~|dataOut[7:1]});
        pll = 1;
        modeSel = UPM_MODE_SYNC;
        go(20);
        chk("on", 8'h14, {dirOut, dirOe, nxtOut, nxtOe, clkIn, clkPd});
        chk("onOe", 8'h00, dataOe);
        chk("onPd", 8'hFF, dataPd);
        dirL = 1'b1;
        nxtL = 1'b1;
        lnkOut = 8'hA5;
        go(2);
        chk("syncDir", 8'h03, {dirOut, nxtOut});
        chk("syncD", 8'hA5, dataOut);
        chk("syncOe", 8'hFF, dataOe);
        dirL = 1'b0;
        nxtL = 1'b0;
        stpLvl = 1'b0;
        go(6);
        chk("stpLowOe", 8'h00, dataOe);
        chk("stpLowPd", 8'h00, dataPd);
        stpLvl = 1'b1;
        go(6);
    endtask
    task automatic t_suspend(input logic off);
        stpOff = off;
        lsDp = ~off;
        lsDm = off;
        inSusp = 1'b1;
        setm(UPM_MODE_SUSPEND);
        chk("susp", 8'h0D, {dirOut, dirOe, nxtOut, nxtOe});
        chk("suspD", {4'h0, 1'b1, 1'b0, off, ~off}, dataOut);
        chk("suspOe", 8'hFF, dataOe);
        chk("suspPu", {7'h00, ~off}, {7'h00, stpPu});
        inSusp = 1'b0;
        setm(UPM_MODE_SYNC);
        stpOff = 0;
        lsDp = 1'b1;
        lsDm = 1'b0;
    endtask
    task automatic t_serial;
        linkOe = 8'h07;
        linkDrive = 8'h05;
        setm(UPM_MODE_SER6);
        chk("s6Oe", 8'hF8, dataOe);
        chk("s6D", 8'h58, dataOut);
        chk("s6Tx", 8'h0B, {txEn, txDat, txSe0, cdrIn});
        diffC = 1'b0;
        go(2);
        chk("s6Rcv", 8'h18, dataOut);
        chk("cdr", 8'h00, {7'h00, cdrIn});
        diffC = 1'b1;
        setm(UPM_MODE_SER3);
        chk("s3Oe", 8'hFA, dataOe);
        chk("s3D", 8'h0A, dataOut);
        sDoe = 1'b0;
        sSoe = 1'b1;
        sSo = 1'b1;
        go(2);
        chk("s3Oe2", 8'hFC, dataOe);
        chk("s3D2", 8'h0E, dataOut);
        chk("s3Tx", 8'h05, {5'h00, txEn, txDat, txSe0});
        sDoe = 1'b1;
        sSoe = 1'b0;
        sSo = 1'b0;
        linkDrive = 8'h04;
        intL = 1'b0;
        setm(UPM_MODE_UART);
        chk("uOe", 8'hFE, dataOe);
        chk("uD", 8'h02, dataOut);
        chk("uTx", 8'h00, {7'h00, uTxd});
        intL = 1'b1;
        linkOe = 8'h00;
    endtask
    task automatic t_speed;
        perRole = 1;
        lsReq = 1;
        go(2);
        chk("lsPer", 8'h00, {7'h00, lsOk});
        perRole = 0;
        go(2);
        chk("lsHost", 8'h01, {7'h00, lsOk});
        clkEn = 1'b0;
        lsReq = 0;
        go(2);
        chk("freeze", 8'h01, {7'h00, lsOk});
        clkEn = 1'b1;
        go(2);
        chk("lsOff", 8'h00, {7'h00, lsOk});
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        rst_n = 0;
        extRstN = 0;
        pll = 0;
        stpOff = 0;
        perRole = 0;
        lsReq = 0;
        inSusp = 0;
        stpLvl = 1;
        linkDrive = 8'h00;
        linkOe = 8'h00;
        modeSel = UPM_MODE_UART;
        clkEn = 1'b1;
        lsDp = 1'b1;
        lsDm = 1'b0;
        diffC = 1'b1;
        intL = 1'b1;
        sDo = 1'b1;
        sDoe = 1'b1;
        sSo = 1'b0;
        sSoe = 1'b0;
        uRx = 1'b1;
        dirL = 1'b0;
        nxtL = 1'b0;
        lnkOut = 8'h00;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1;
        // external reset held well over 200 ns
        go(8);
        t_powerup();
        t_suspend(1'b0);
        t_suspend(1'b1);
        t_serial();
        t_speed();
        report_and_stop();
    end
    initial
    begin
        #50000;
        failures++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire

/* File: dv/upm_link_model.sv */
// Purpose: link controller model at the ULPI data and STP pins
// Assumes: the link drives only the data pins that the device leaves free
// Notes:   an undriven data pin without pulldown shows its last value inverted
`timescale 1ns/1ps
`default_nettype none
module upm_link_model (
    input  wire logic       ulpiClk,
    input  wire logic       inSuspend,
    input  wire logic       stpLevel,
    input  wire logic [7:0] linkDrive,
    input  wire logic [7:0] linkOe,
    input  wire logic [7:0] dataOut,
    input  wire logic [7:0] dataOe,
    input  wire logic [7:0] dataPullDown,
    output var  logic [7:0] dataIn,
    output var  logic       stpIn
);
    logic [7:0] lastQ;
    always_ff @(posedge ulpiClk)
    begin
        lastQ <= dataIn;
    end
    assign stpIn = inSuspend ? 1'b0 : stpLevel;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            dataIn[i] = dataOe[i] ? dataOut[i] : linkOe[i] ? linkDrive[i] : dataPullDown[i] ? 1'b0 : ~lastQ[i];
        end
    end
endmodule // upm_link_model
`default_nettype wire

/* File: hdl/upm_pad_reset.sv */
// Purpose: pad reset generator on the ULPI clock
// Assumes: external reset arrives asynchronously
// Notes:   pad reset asserts asynchronously, releases synchronously
`timescale 1ns/1ps
`default_nettype none
module upm_pad_reset (
    input  wire logic ulpiClk,
    input  wire logic externalResetN,
    output var  logic padResetInternal
);
    typedef struct packed {
        logic s1;
        logic s2;
    } upm_rst_s;

    upm_rst_s st_q;
    upm_rst_s st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = 1'b1;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge ulpiClk or negedge externalResetN)
    begin
        if (!externalResetN)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign padResetInternal = ~st_q.s2;
endmodule // upm_pad_reset
`default_nettype wire

/* File: hdl/upm_pin_mode.sv */
// Purpose: ULPI pin direction, level and pull control across operating modes
// Assumes: mode, suspend pull option and serial signals come from sys_clk logic
// Notes:   pin side runs on ulpiClk; mode crosses by three-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module upm_pin_mode
    import upm_pkg::*;
#(
    parameter int DIR_DELAY_CYC = upm_pkg::UPM_DIR_DELAY_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              ulpiClk,
    input  wire logic              externalResetN,
    input  wire logic              pllLocked,
    input  wire upm_pkg::upm_mode_e modeSel,
    input  wire logic              stpPullOffInSuspend,
    input  wire logic              peripheralRole,
    input  wire logic              lowSpeedReq,
    input  wire logic              lineStateDp,
    input  wire logic              lineStateDm,
    input  wire logic              diffCompOut,
    input  wire logic              intLevel,
    input  wire logic              serDatOut,
    input  wire logic              serDatOe,
    input  wire logic              serSe0Out,
    input  wire logic              serSe0Oe,
    input  wire logic              uartRxd,
    input  wire logic              dirLevel,
    input  wire logic              nxtLevel,
    input  wire logic [7:0]        linkDataOut,
    input  wire logic [7:0]        dataIn,
    input  wire logic              stpIn,
    output var  logic [7:0]        dataOut,
    output var  logic [7:0]        dataOe,
    output var  logic [7:0]        dataPullDown,
    output var  logic              dirOut,
    output var  logic              dirOe,
    output var  logic              dirPullUp,
    output var  logic              nxtOut,
    output var  logic              nxtOe,
    output var  logic              nxtPullDown,
    output var  logic              stpPullUp,
    output var  logic              clkPinIsInput,
    output var  logic              clkPinPullDown,
    output var  logic              padResetInternal,
    output var  logic              txEnable,
    output var  logic              txData,
    output var  logic              txSe0,
    output var  logic              uartTxd,
    output var  logic              cdrIn,
    output var  logic              lowSpeedAllowed,
    output var  logic [2:0]        modeActive
);
    import upm_pkg::*;

    // ************************************************************
    // pad reset and crossings
    // ************************************************************
    logic       padRst;
    logic       ulpiRstN;
    logic [2:0] modeSync;
    logic       pllSync;
    logic       stpSync;
    logic       pullOffSync;

    upm_pad_reset u_pad_reset (
        .ulpiClk          (ulpiClk),
        .externalResetN   (externalResetN),
        .padResetInternal (padRst)
    );

    assign ulpiRstN = ~padRst;

    upm_sync3 #(.W(6)) u_sync (
        .clk  (ulpiClk),
        .rstN (ulpiRstN),
        .ce   (1'b1),
        .din  ({modeSel, pllLocked, stpIn, stpPullOffInSuspend}),
        .dout ({modeSync, pllSync, stpSync, pullOffSync})
    );

    // ************************************************************
    // link-side state
    // ************************************************************
    typedef struct packed {
        upm_phase_e  phase;
        logic [2:0]  mode;
        logic [19:0] dirCnt;
        logic        pullOff;
        logic [7:0]  dOut;
        logic [7:0]  dOe;
        logic [7:0]  dPd;
        logic        dir;
        logic        nxt;
        logic        stpPu;
        logic        clkIn;
        logic        clkPd;
    } upm_link_s;

    upm_link_s lk_q;
    upm_link_s lk_d;

    always_comb
    begin
        lk_d = lk_q;
        case (lk_q.phase)
            UPM_PH_RESET:
            begin
                lk_d.phase = UPM_PH_PLLOFF;
            end
            UPM_PH_PLLOFF:
            begin
                if (pllSync && lk_q.dirCnt >= 20'(DIR_DELAY_CYC - 1))
                begin
                    lk_d.phase = UPM_PH_RUN;
                end
                else if (pllSync)
                begin
                    lk_d.dirCnt = lk_q.dirCnt + 20'h00001;
                end
            end
            UPM_PH_RUN:
            begin
                lk_d.phase = UPM_PH_RUN;
            end
            default:
            begin
                lk_d.phase = UPM_PH_RESET;
            end
        endcase
        if (modeSync != lk_q.mode)
        begin
            lk_d.mode = modeSync;
        end
        if (lk_q.mode != 3'(UPM_MODE_SUSPEND))
        begin
            lk_d.pullOff = pullOffSync;
        end

        lk_d.dOut  = UPM_ALL_ZERO;
        lk_d.dOe   = UPM_ALL_ONE;
        lk_d.dPd   = UPM_ALL_ZERO;
        lk_d.dir   = 1'b1;
        lk_d.nxt   = 1'b0;
        lk_d.clkIn = 1'b1;
        lk_d.clkPd = 1'b0;
        lk_d.stpPu = 1'b1;
        if (lk_d.phase != UPM_PH_RUN)
        begin
            lk_d.clkPd = 1'b1;
        end
        else
        begin
            lk_d.clkIn = 1'b0;
            case (lk_d.mode)
                3'(UPM_MODE_SYNC):
                begin
                    lk_d.dir  = dirLevel;
                    lk_d.nxt  = nxtLevel;
                    lk_d.dOut = linkDataOut;
                    lk_d.dOe  = dirLevel ? UPM_ALL_ONE : UPM_ALL_ZERO;
                    lk_d.dPd  = (stpSync && !dirLevel) ? UPM_ALL_ONE : UPM_ALL_ZERO;
                end
                3'(UPM_MODE_SUSPEND):
                begin
                    lk_d.clkIn            = 1'b1;
                    lk_d.dOut[UPM_D_LS0]  = lineStateDp;
                    lk_d.dOut[UPM_D_LS1]  = lineStateDm;
                    lk_d.dOut[UPM_D_INT]  = intLevel;
                    lk_d.stpPu            = ~lk_d.pullOff;
                end
                3'(UPM_MODE_SER6):
                begin
                    lk_d.dOe[UPM_D_TXEN]   = 1'b0;
                    lk_d.dOe[UPM_D_TXDAT]  = 1'b0;
                    lk_d.dOe[UPM_D_SE0]    = 1'b0;
                    lk_d.dOut[UPM_D_INT]   = intLevel;
                    lk_d.dOut[UPM_D_RXDP]  = lineStateDp;
                    lk_d.dOut[UPM_D_RXDM]  = lineStateDm;
                    lk_d.dOut[UPM_D_RXRCV] = diffCompOut;
                end
                3'(UPM_MODE_SER3):
                begin
                    lk_d.dOe[UPM_D_TXEN]   = 1'b0;
                    lk_d.dOe[UPM_D_TXDAT]  = serDatOe;
                    lk_d.dOut[UPM_D_TXDAT] = serDatOut;
                    lk_d.dOe[UPM_D_SE0]    = serSe0Oe;
                    lk_d.dOut[UPM_D_SE0]   = serSe0Out;
                    lk_d.dOut[UPM_D_INT]   = intLevel;
                end
                3'(UPM_MODE_UART):
                begin
                    lk_d.dOe[UPM_D_TXEN]   = 1'b0;
                    lk_d.dOut[UPM_D_TXDAT] = uartRxd;
                    lk_d.dOut[UPM_D_INT]   = intLevel;
                end
                default:
                begin
                    lk_d.dOut = UPM_ALL_ZERO;
                end
            endcase
            // unused pins stay low through default zero
        end
    end

    always_ff @(posedge ulpiClk or negedge ulpiRstN)
    begin
        if (!ulpiRstN)
        begin
            lk_q       <= '0;
            lk_q.phase <= UPM_PH_RESET;
            lk_q.dir   <= 1'b1;
            lk_q.stpPu <= 1'b1;
            lk_q.clkIn <= 1'b1;
            lk_q.clkPd <= 1'b1;
            lk_q.dPd   <= UPM_ALL_ONE;
        end
        else
        begin
            lk_q <= lk_d;
        end
    end

    // ************************************************************
    // pin outputs
    // ************************************************************
    // float with weak pulls in reset
    assign dataOut          = padRst ? UPM_ALL_ZERO : lk_q.dOut;
    assign dataOe           = padRst ? UPM_ALL_ZERO : lk_q.dOe;
    assign dataPullDown     = padRst ? UPM_ALL_ONE : lk_q.dPd;
    assign dirOut           = ~padRst & lk_q.dir;
    assign dirOe            = ~padRst;
    assign dirPullUp        = padRst;
    assign nxtOut           = ~padRst & lk_q.nxt;
    assign nxtOe            = ~padRst;
    assign nxtPullDown      = padRst;
    assign clkPinIsInput    = padRst | lk_q.clkIn;
    assign clkPinPullDown   = padRst | lk_q.clkPd;
    assign stpPullUp        = padRst | lk_q.stpPu;
    assign padResetInternal = padRst;

    // ************************************************************
    // system-side state
    // ************************************************************
    logic [7:0] dSync;

    upm_sync3 #(.W(8)) u_dsync (
        .clk  (sys_clk),
        .rstN (rst_n),
        .ce   (clkEn),
        .din  (dataIn),
        .dout (dSync)
    );

    typedef struct packed {
        logic       txEn;
        logic       txDat;
        logic       txSe;
        logic       uTx;
        logic       cdr;
        logic       lsOk;
        logic [2:0] mode;
    } upm_sys_s;

    upm_sys_s sy_q;
    upm_sys_s sy_d;

    always_comb
    begin
        sy_d       = sy_q;
        sy_d.mode  = modeSel;
        sy_d.txEn  = (modeSel == UPM_MODE_SER6 || modeSel == UPM_MODE_SER3) & dSync[UPM_D_TXEN];
        sy_d.txDat = (modeSel == UPM_MODE_SER6 || modeSel == UPM_MODE_SER3) & dSync[UPM_D_TXDAT];
        sy_d.txSe  = (modeSel == UPM_MODE_SER6 || modeSel == UPM_MODE_SER3) & dSync[UPM_D_SE0];
        sy_d.uTx   = (modeSel == UPM_MODE_UART) ? dSync[UPM_D_TXEN] : 1'b1;
        sy_d.cdr   = diffCompOut;
        sy_d.lsOk  = lowSpeedReq & ~peripheralRole;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy_q <= '0;
        end
        else if (clkEn)
        begin
            sy_q <= sy_d;
        end
    end

    assign txEnable        = sy_q.txEn;
    assign txData          = sy_q.txDat;
    assign txSe0           = sy_q.txSe;
    assign uartTxd         = sy_q.uTx;
    assign cdrIn           = sy_q.cdr;
    assign lowSpeedAllowed = sy_q.lsOk;
    assign modeActive      = sy_q.mode;

    // ************************************************************
    // checks
    // ************************************************************
    property p_stp_pull;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.mode != 3'(UPM_MODE_SUSPEND)) |-> stpPullUp;
    endproperty
    a_stp_pull: assert property (p_stp_pull) else $error("stp pullup lost");

    property p_suspend_dir;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.phase == UPM_PH_RUN && lk_q.mode == 3'(UPM_MODE_SUSPEND)) |-> (dirOut && !nxtOut && clkPinIsInput);
    endproperty
    a_suspend_dir: assert property (p_suspend_dir) else $error("suspend dir wrong");

    property p_ser6_d7;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.phase == UPM_PH_RUN && lk_q.mode == 3'(UPM_MODE_SER6)) |-> (dataOe[7] && !dataOut[7] && !dataOe[0]);
    endproperty
    a_ser6_d7: assert property (p_ser6_d7) else $error("six-pin map wrong");

    property p_ser3_low;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.phase == UPM_PH_RUN && lk_q.mode == 3'(UPM_MODE_SER3)) |-> (dataOut[7:4] == 4'h0 && dataOe[7:4] == 4'hF);
    endproperty
    a_ser3_low: assert property (p_ser3_low) else $error("three-pin unused not low");

    property p_uart_map;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.phase == UPM_PH_RUN && lk_q.mode == 3'(UPM_MODE_UART)) |-> (!dataOe[0] && !dataOut[2] && dirOe && nxtOe);
    endproperty
    a_uart_map: assert property (p_uart_map) else $error("uart map wrong");

    property p_plloff_dir;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.phase == UPM_PH_PLLOFF) |-> (dirOut && dataOut == 8'h00 && dataOe == 8'hFF);
    endproperty
    a_plloff_dir: assert property (p_plloff_dir) else $error("pll-off levels wrong");

    property p_mode_hold;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        ($stable(modeSync) && modeSync == lk_q.mode) |=> $stable(lk_q.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without selector");

    property p_no_ls_periph;
        @(posedge sys_clk) disable iff (!rst_n)
        (clkEn && peripheralRole) |=> !lowSpeedAllowed;
    endproperty
    a_no_ls_periph: assert property (p_no_ls_periph) else $error("low speed as peripheral");

    property p_rcv_raw;
        @(posedge ulpiClk) disable iff (!ulpiRstN)
        (lk_q.phase == UPM_PH_RUN && lk_d.mode == 3'(UPM_MODE_SER6) && lk_q.mode == 3'(UPM_MODE_SER6))
            |=> (dataOut[6] == $past(diffCompOut));
    endproperty
    a_rcv_raw: assert property (p_rcv_raw) else $error("receive pin not raw");

endmodule // upm_pin_mode
`default_nettype wire

/* File: hdl/upm_pkg.sv */
// Purpose: shared constants for the ULPI pin mode control block
// Assumes: twelve ULPI pins, data pins indexed 0..7
// Notes:   mode codes, pin indices and timing figures
package upm_pkg;

    // ************************************************************
    // mode selector
    // ************************************************************
    typedef enum logic [2:0] {
        UPM_MODE_SYNC    = 3'h0,
        UPM_MODE_SUSPEND = 3'h1,
        UPM_MODE_SER6    = 3'h2,
        UPM_MODE_SER3    = 3'h3,
        UPM_MODE_UART    = 3'h4
    } upm_mode_e;

    // ************************************************************
    // internal pin phase
    // ************************************************************
    typedef enum logic [1:0] {
        UPM_PH_RESET   = 2'h0,
        UPM_PH_PLLOFF  = 2'h1,
        UPM_PH_RUN     = 2'h2
    } upm_phase_e;

    // ************************************************************
    // data pin positions
    // ************************************************************
    localparam int UPM_D_TXEN  = 0;
    localparam int UPM_D_TXDAT = 1;
    localparam int UPM_D_SE0   = 2;
    localparam int UPM_D_INT   = 3;
    localparam int UPM_D_RXDP  = 4;
    localparam int UPM_D_RXDM  = 5;
    localparam int UPM_D_RXRCV = 6;
    localparam int UPM_D_LS0   = 0;
    localparam int UPM_D_LS1   = 1;

    localparam logic [7:0] UPM_ALL_ZERO = 8'h00;
    localparam logic [7:0] UPM_ALL_ONE  = 8'hFF;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int UPM_CLK_MHZ        = 60;
    localparam int UPM_T_RST_MIN_NS   = 200;
    localparam int UPM_T_DIR_TYP_MS_X100 = 54;
    localparam int UPM_DIR_DELAY_CYC  = (UPM_T_DIR_TYP_MS_X100 * UPM_CLK_MHZ * 1000) / 100;

endpackage

/* File: hdl/upm_sync3.sv */
// Purpose: three-stage synchroniser, change accepted when stages 2 and 3 agree
// Assumes: input asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module upm_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstN,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } upm_sync_s;

    upm_sync_s st_q;
    upm_sync_s st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.o[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            st_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.o;
endmodule // upm_sync3
`default_nettype wire
